// ### core/adc_conversion_control.sv
// Conversion control, indirect module ports and register file of the converter module
`include "adc_cc_defines.svh"
module adc_conversion_control (
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	// CPU writes to its module ports, and the CPU halt
	input  wire logic                    cpu_port_we,
	input  wire logic [1:0]              cpu_port_sel,
	input  wire logic [15:0]             cpu_port_wdata,
	output logic      [15:0]             module_data_port,
	output logic      [15:0]             module_address_port,
	output logic      [15:0]             module_control_port,
	output logic                         cpu_halt,
	// Converter core
	output logic                         adc_start,
	output adc_cc_pkg::conv_target_t     adc_channel,
	output logic      [3:0]              adc_source_sel,
	output logic                         adc_positive_pin_only,
	output logic                         adc_negative_pin_only,
	output logic      [15:0]             adc_setup_a,
	output logic      [15:0]             adc_setup_b,
	input  wire logic                    adc_done,
	input  wire logic [15:0]             adc_result
);
	import adc_cc_pkg::*;

	localparam int NUM_SETUP = 6;
	localparam logic [7:0]  SETUP_OFS [NUM_SETUP] = '{
		`OFS_CHAN1_SETUP_A, `OFS_CHAN1_SETUP_B, `OFS_CHAN2_SETUP_A,
		`OFS_CHAN2_SETUP_B, `OFS_TEMP_SETUP_A, `OFS_TEMP_SETUP_B};
	localparam logic [15:0] SETUP_RST [NUM_SETUP] = '{
		`RST_WORD_ZERO, `RST_SETUP_B, `RST_WORD_ZERO,
		`RST_WORD_ZERO, `RST_WORD_ZERO, `RST_SETUP_B};

	conv_state_t  state_reg;
	conv_target_t target_sel;
	logic         target_unsupported;
	logic [15:0]  control_reg;
	logic [15:0]  chan1_result_reg;
	logic [15:0]  chan2_result_reg;
	logic [15:0]  temp_result_reg;
	logic [15:0]  setup_q [NUM_SETUP];
	logic [7:0]   addr8;
	logic         xfer_read;
	logic         xfer_write;
	logic [15:0]  read_data;
	logic [NUM_SETUP-1:0] setup_we;
	logic         control_we;
	logic         conv_complete;
	logic [3:0]   single_ended_source_sel;

	// ---------------------------------------------------------------
	// Module port transfers
	// ---------------------------------------------------------------
	assign addr8      = module_address_port[7:0];
	assign xfer_read  = module_control_port[`PF_GO_BIT] & module_control_port[`PF_READ_BIT];
	assign xfer_write = module_control_port[`PF_GO_BIT] & ~module_control_port[`PF_READ_BIT];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			module_data_port <= `RST_WORD_ZERO;
		end else if (cpu_port_we && cpu_port_sel == `PORT_SEL_DATA) begin
			module_data_port <= cpu_port_wdata;
		end else if (xfer_read) begin
			module_data_port <= read_data;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			module_address_port <= `RST_WORD_ZERO;
		end else if (cpu_port_we && cpu_port_sel == `PORT_SEL_ADDRESS) begin
			module_address_port <= cpu_port_wdata;
		end
	end

	// A fresh CPU write of the port wins over the self-clear of the go bit
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			module_control_port <= `RST_WORD_ZERO;
		end else if (cpu_port_we && cpu_port_sel == `PORT_SEL_CONTROL) begin
			module_control_port <= cpu_port_wdata;
		end else if (module_control_port[`PF_GO_BIT]) begin
			module_control_port[`PF_GO_BIT] <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	always_comb begin
		read_data = `RST_WORD_ZERO;
		unique case (addr8)
			`OFS_CONTROL:      read_data = control_reg;
			`OFS_CHAN1_RESULT: read_data = chan1_result_reg;
			`OFS_CHAN2_RESULT: read_data = chan2_result_reg;
			`OFS_TEMP_RESULT:  read_data = temp_result_reg;
			default: begin
				for (int i = 0; i < NUM_SETUP; i++) begin
					if (addr8 == SETUP_OFS[i]) begin
						read_data = setup_q[i];
					end
				end
			end
		endcase
	end

	assign control_we = xfer_write && addr8 == `OFS_CONTROL;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SETUP; gi++) begin : g_setup
			assign setup_we[gi] = xfer_write && addr8 == SETUP_OFS[gi];
			setup_word #(
				.RESET_VALUE(SETUP_RST[gi])
			) u_setup (
				.core_clk(core_clk),
				.resetn  (resetn),
				.we      (setup_we[gi]),
				.wdata   (module_data_port),
				.q       (setup_q[gi])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Control register
	// ---------------------------------------------------------------
	assign single_ended_source_sel = control_reg[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
	assign conv_complete = state_reg == ST_BUSY && adc_done;

	// A software write wins over the hardware clear in the same cycle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			control_reg <= `RST_WORD_ZERO;
		end else if (control_we) begin
			control_reg <= module_data_port & `CTRL_WRITE_MASK;
		end else if (conv_complete) begin
			control_reg <= control_reg & ~`CTRL_START_MASK;
		end else if (state_reg == ST_IDLE && target_unsupported) begin
			control_reg[`CTRL_START_TEMP] <= 1'b0;
		end
	end

	conv_priority u_priority (
		.start_chan1            (control_reg[`CTRL_START_CHAN1]),
		.start_chan2            (control_reg[`CTRL_START_CHAN2]),
		.start_temp             (control_reg[`CTRL_START_TEMP]),
		.single_ended_source_sel(single_ended_source_sel),
		.target                 (target_sel),
		.unsupported            (target_unsupported)
	);

	// ---------------------------------------------------------------
	// Conversion sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			cpu_halt  <= 1'b0;
			adc_start <= 1'b0;
		end else begin
			adc_start <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (target_sel != TGT_NONE) begin
						state_reg <= ST_BUSY;
						cpu_halt  <= 1'b1;
						adc_start <= 1'b1;
					end
				end
				ST_BUSY: begin
					if (adc_done) begin
						state_reg <= ST_IDLE;
						cpu_halt  <= 1'b0;
					end
				end
			endcase
		end
	end

	// Converter settings are frozen for the whole conversion
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			adc_channel           <= TGT_NONE;
			adc_source_sel        <= `SEL_DIFFERENTIAL;
			adc_positive_pin_only <= 1'b0;
			adc_negative_pin_only <= 1'b0;
			adc_setup_a           <= `RST_WORD_ZERO;
			adc_setup_b           <= `RST_WORD_ZERO;
		end else if (state_reg == ST_IDLE && target_sel != TGT_NONE) begin
			adc_channel           <= target_sel;
			adc_source_sel        <= single_ended_source_sel;
			adc_positive_pin_only <= single_ended_source_sel == `SEL_POSITIVE_PIN;
			adc_negative_pin_only <= single_ended_source_sel == `SEL_NEGATIVE_PIN;
			adc_setup_a           <= setup_q[2 * int'(target_sel)];
			adc_setup_b           <= setup_q[2 * int'(target_sel) + 1];
		end
	end

	// ---------------------------------------------------------------
	// Result registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			chan1_result_reg <= `RST_WORD_ZERO;
			chan2_result_reg <= `RST_WORD_ZERO;
			temp_result_reg  <= `RST_WORD_ZERO;
		end else if (conv_complete) begin
			unique case (adc_channel)
				TGT_CHAN1: chan1_result_reg <= adc_result;
				TGT_CHAN2: chan2_result_reg <= adc_result;
				TGT_TEMP:  temp_result_reg  <= adc_result;
				TGT_NONE:  chan1_result_reg <= chan1_result_reg;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	sequence seq_idle_with(logic [2:0] starts);
		state_reg == ST_IDLE && !control_we && control_reg[2:0] == starts;
	endsequence

	sequence seq_launch(conv_target_t tgt);
		adc_start && cpu_halt && adc_channel == tgt && state_reg == ST_BUSY;
	endsequence

	sequence seq_finish;
		conv_complete && !control_we;
	endsequence

	a_chan1_first: assert property (
		(state_reg == ST_IDLE && control_reg[`CTRL_START_CHAN1]) |=> seq_launch(TGT_CHAN1))
		else $error("channel 1 start did not launch channel 1");

	a_chan2_second: assert property (
		(state_reg == ST_IDLE && control_reg[2:1] == 2'b01) |=> seq_launch(TGT_CHAN2))
		else $error("channel 2 start did not launch channel 2");

	a_temp_diff_only: assert property (
		(seq_idle_with(3'b001) and single_ended_source_sel == `SEL_DIFFERENTIAL)
		|=> seq_launch(TGT_TEMP))
		else $error("temperature start did not launch temperature");

	a_temp_unsupported: assert property (
		(seq_idle_with(3'b001) and single_ended_source_sel != `SEL_DIFFERENTIAL)
		|=> !adc_start && !cpu_halt && !control_reg[`CTRL_START_TEMP])
		else $error("unsupported temperature combination converted");

	a_halt_while_busy: assert property (
		state_reg == ST_BUSY |-> cpu_halt)
		else $error("cpu not halted during conversion");

	a_no_start_no_halt: assert property (
		seq_idle_with(3'b000) |=> !cpu_halt && !adc_start && $stable(chan1_result_reg)
		&& $stable(chan2_result_reg) && $stable(temp_result_reg))
		else $error("activity without any start bit");

	a_start_self_clear: assert property (
		seq_finish |=> control_reg[2:0] == 3'b000 && !cpu_halt ##1 state_reg == ST_IDLE)
		else $error("start bits not cleared after conversion");

	a_result_stored: assert property (
		(conv_complete && adc_channel == TGT_CHAN2) |=> chan2_result_reg == $past(adc_result))
		else $error("channel 2 result not stored");

	a_read_overwrites: assert property (
		(xfer_read && !(cpu_port_we && cpu_port_sel == `PORT_SEL_DATA))
		|=> module_data_port == $past(read_data))
		else $error("module read did not load the data port");

	a_write_keeps_data: assert property (
		(xfer_write && !(cpu_port_we && cpu_port_sel == `PORT_SEL_DATA))
		|=> $stable(module_data_port))
		else $error("module write altered the data port");

	a_go_self_clear: assert property (
		(module_control_port[`PF_GO_BIT] && !(cpu_port_we && cpu_port_sel == `PORT_SEL_CONTROL))
		|=> !module_control_port[`PF_GO_BIT])
		else $error("transfer go bit did not clear");

	a_ctrl_unused_zero: assert property (
		(control_reg & ~`CTRL_WRITE_MASK) == 16'h0000)
		else $error("unused control bits not zero");

	a_start_single_pulse: assert property (
		adc_start |=> !adc_start)
		else $error("converter start lasted more than one cycle");

	a_chan1_result_stored: assert property (
		(conv_complete && adc_channel == TGT_CHAN1) |=> chan1_result_reg == $past(adc_result))
		else $error("channel 1 result not stored");

	a_temp_result_stored: assert property (
		(conv_complete && adc_channel == TGT_TEMP) |=> temp_result_reg == $past(adc_result))
		else $error("temperature result not stored");

	a_settings_frozen: assert property (
		(state_reg == ST_BUSY && !conv_complete)
		|=> $stable(adc_channel) && $stable(adc_setup_a) && $stable(adc_setup_b))
		else $error("converter settings changed during conversion");
endmodule : adc_conversion_control

// ### core/adc_cc_defines.svh
// Register offsets, field positions, reset values and port encodings of the conversion control
// Contract
// - Control bit 2 starts a channel-1 conversion using channel-1 setups, result to channel-1
// - Control bit 1 starts a channel-2 conversion using channel-2 setups, result to channel-2
// - Control bit 0 starts a temperature conversion using temperature setups and result
// - The CPU is held halted while any conversion runs
// - All three start bits clear together once any conversion completed and was stored
// - Control bits 11 down to 8 hold the single-ended source selector
// - Channel-1 start with selector 0000 converts differential input 1, others ignored
// - Channel-2 start alone with selector 0000 converts differential input 2
// - Temperature converts only when it alone is set and selector is 0000
// - Temperature start alone with nonzero selector yields no temperature result
// - Channel-2 start alone, nonzero selector: single-ended source, channel-2 settings
// - Channel-1 start, nonzero selector: single-ended source, channel-1 settings
// - Three result registers are read-only and hold the latest results
// - Setup B of channel 1 and temperature reset to 0070h, others to 0000h
// - Control at 00h, setups and results up to 09h, all 16-bit words
// - Only the low eight address-port bits are decoded
// - Control-port bit 15 starts a transfer, bit 14 chooses read, bit 15 self-clears
// - A read overwrites the data port; a write leaves it unchanged
// - Selector 1000 picks the positive pin, 1001 the negative pin, against ground
`ifndef ADC_CC_DEFINES_SVH
`define ADC_CC_DEFINES_SVH

`define OFS_CONTROL        8'h00
`define OFS_CHAN1_RESULT   8'h01
`define OFS_CHAN1_SETUP_A  8'h02
`define OFS_CHAN1_SETUP_B  8'h03
`define OFS_CHAN2_RESULT   8'h04
`define OFS_CHAN2_SETUP_A  8'h05
`define OFS_CHAN2_SETUP_B  8'h06
`define OFS_TEMP_RESULT    8'h07
`define OFS_TEMP_SETUP_A   8'h08
`define OFS_TEMP_SETUP_B   8'h09

`define CTRL_START_CHAN1   2
`define CTRL_START_CHAN2   1
`define CTRL_START_TEMP    0
`define CTRL_SEL_MSB       11
`define CTRL_SEL_LSB       8
`define CTRL_WRITE_MASK    16'h0F07
`define CTRL_START_MASK    16'h0007

`define SEL_DIFFERENTIAL   4'h0
`define SEL_POSITIVE_PIN   4'h8
`define SEL_NEGATIVE_PIN   4'h9

`define PF_GO_BIT          15
`define PF_READ_BIT        14

`define PORT_SEL_DATA      2'h0
`define PORT_SEL_ADDRESS   2'h1
`define PORT_SEL_CONTROL   2'h2

`define RST_WORD_ZERO      16'h0000
`define RST_SETUP_B        16'h0070

`endif

// ### core/adc_cc_pkg.sv
// Types shared by the conversion control modules
package adc_cc_pkg;
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} conv_state_t;

	typedef enum logic [1:0] {
		TGT_CHAN1 = 2'b00,
		TGT_CHAN2 = 2'b01,
		TGT_TEMP  = 2'b10,
		TGT_NONE  = 2'b11
	} conv_target_t;
endpackage : adc_cc_pkg

// ### core/setup_word.sv
// One 16-bit read/write setup word with a chosen power-on value
module setup_word #(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        we,
	input  wire logic [15:0] wdata,
	output logic      [15:0] q
);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			q <= RESET_VALUE;
		end else if (we) begin
			q <= wdata;
		end
	end
endmodule : setup_word

// ### core/conv_priority.sv
// Fixed-priority choice of the input to convert from the start bits and the selector
`include "adc_cc_defines.svh"
module conv_priority (
	input  wire logic                    start_chan1,
	input  wire logic                    start_chan2,
	input  wire logic                    start_temp,
	input  wire logic [3:0]              single_ended_source_sel,
	output adc_cc_pkg::conv_target_t     target,
	output logic                         unsupported
);
	import adc_cc_pkg::*;

	always_comb begin
		target      = TGT_NONE;
		unsupported = 1'b0;
		if (start_chan1) begin
			target = TGT_CHAN1;
		end else if (start_chan2) begin
			target = TGT_CHAN2;
		end else if (start_temp) begin
			if (single_ended_source_sel == `SEL_DIFFERENTIAL) begin
				target = TGT_TEMP;
			end else begin
				unsupported = 1'b1;
			end
		end
	end
endmodule : conv_priority

// ### testbench/adc_model.sv
// Behavioural converter core that answers the conversion control
module adc_model (
	input  wire logic                     core_clk,
	input  wire logic                     resetn,
	input  wire logic [1:0]               lat,
	input  wire logic                     adc_start,
	input  wire adc_cc_pkg::conv_target_t adc_channel,
	input  wire logic [3:0]               adc_source_sel,
	input  wire logic [15:0]              adc_setup_a,
	input  wire logic [15:0]              adc_setup_b,
	output logic                          adc_done,
	output logic      [15:0]              adc_result
);
	timeunit 1ns;
	timeprecision 1ps;
	import adc_cc_pkg::*;
	logic        busy_reg;
	logic [1:0]  cnt_reg;
	logic [15:0] last_reg;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy_reg <= 1'h0;
			cnt_reg  <= 2'h0;
			last_reg <= 16'h0000;
		end else if (adc_start) begin
			busy_reg <= 1'h1;
			cnt_reg  <= lat;
		end else if (adc_done) begin
			busy_reg <= 1'h0;
			last_reg <= adc_result;
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg - 2'h1;
		end
	end
	assign adc_done = busy_reg && cnt_reg == 2'h0;
	// Result depends on the latched setups and source; outside done the line shows junk
	assign adc_result = adc_done ? adc_setup_a + adc_setup_b + {adc_source_sel, 10'h000, adc_channel}
		: ~last_reg;
endmodule : adc_model

// ### testbench/adc_conversion_control_tb.sv
// Self-checking bench of the conversion control with a converter model
`include "adc_cc_defines.svh"
module adc_conversion_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_cc_pkg::*;
	logic core_clk = 1'h0;
	logic resetn = 1'h0;
	logic cpu_port_we = 1'h0;
	logic [1:0] cpu_port_sel = 2'h0;
	logic [15:0] cpu_port_wdata = 16'h0000;
	logic [1:0] lat = 2'h0;
	logic [15:0] module_data_port, module_address_port, module_control_port;
	logic cpu_halt, adc_start, adc_done, adc_pos, adc_neg;
	conv_target_t adc_channel;
	logic [3:0] adc_source_sel;
	logic [15:0] adc_setup_a, adc_setup_b, adc_result;
	logic [31:0] seed = 32'h0000D5EB;
	int n_mismatch = 0;
	int checks_done = 0;
	logic [15:0] su [3][2];
	logic [15:0] res [3] = '{16'h0000, 16'h0000, 16'h0000};
	logic [7:0] saddr [3][2] = '{'{8'h02, 8'h03}, '{8'h05, 8'h06}, '{8'h08, 8'h09}};
	logic [7:0] raddr [3] = '{`OFS_CHAN1_RESULT, `OFS_CHAN2_RESULT, `OFS_TEMP_RESULT};
	logic [15:0] rstv [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0070, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0070};
	logic [15:0] clist [11] = '{16'h0004, 16'h0006, 16'h0007, 16'h0002, 16'h0003, 16'h0001,
		16'h0804, 16'h0902, 16'h0801, 16'h0000, 16'hFFF8};

	always #4 core_clk = ~core_clk;

	adc_conversion_control u_dut (.core_clk(core_clk), .resetn(resetn),
		.cpu_port_we(cpu_port_we), .cpu_port_sel(cpu_port_sel),
		.cpu_port_wdata(cpu_port_wdata), .module_data_port(module_data_port),
		.module_address_port(module_address_port), .module_control_port(module_control_port),
		.cpu_halt(cpu_halt), .adc_start(adc_start), .adc_channel(adc_channel),
		.adc_source_sel(adc_source_sel), .adc_positive_pin_only(adc_pos),
		.adc_negative_pin_only(adc_neg), .adc_setup_a(adc_setup_a),
		.adc_setup_b(adc_setup_b), .adc_done(adc_done), .adc_result(adc_result));
	adc_model u_model (.core_clk(core_clk), .resetn(resetn), .lat(lat), .adc_start(adc_start),
		.adc_channel(adc_channel), .adc_source_sel(adc_source_sel),
		.adc_setup_a(adc_setup_a), .adc_setup_b(adc_setup_b), .adc_done(adc_done),
		.adc_result(adc_result));

	function logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction : rnd

	function logic [1:0] target(input logic [15:0] c);
		if (c[2]) return 2'h0;
		if (c[1]) return 2'h1;
		if (c[0] && c[11:8] == 4'h0) return 2'h2;
		return 2'h3;
	endfunction : target

	task stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Entered just after an edge; leaves one idle edge so strobes never re-arm in one step
	task port_wr(input logic [1:0] sel, input logic [15:0] d);
		cpu_port_sel = sel;
		cpu_port_wdata = d;
		cpu_port_we = 1'h1;
		@(posedge core_clk);
		#1 cpu_port_we = 1'h0;
		@(posedge core_clk);
		#1;
	endtask : port_wr

	task reg_xfer(input logic rd, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		logic [15:0] r;
		r = rnd();
		port_wr(`PORT_SEL_DATA, d);
		port_wr(`PORT_SEL_ADDRESS, {r[15:8], a});
		port_wr(`PORT_SEL_CONTROL, rd ? 16'hC000 : 16'h8000);
		q = module_data_port;
		chk("address port", {r[15:8], a}, module_address_port);
		chk("control port", rd ? 16'h4000 : 16'h0000, module_control_port);
		if (!rd) chk("data port kept", d, q);
	endtask : reg_xfer

	task reg_rd(input logic [7:0] a, input logic [15:0] exp, input string what);
		logic [15:0] q;
		reg_xfer(1'h1, a, ~exp, q);
		chk(what, exp, q);
	endtask : reg_rd

	task reg_wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		reg_xfer(1'h0, a, d, q);
	endtask : reg_wr

	task conv(input logic [15:0] c);
		logic [1:0] t;
		logic [3:0] s;
		t = target(c);
		s = c[11:8];
		lat = 2'(rnd());
		reg_wr(`OFS_CONTROL, c);
		@(posedge core_clk);
		#1;
		chk("halt", {15'h0000, t != 2'h3}, {15'h0000, cpu_halt});
		chk("start pulse", {15'h0000, t != 2'h3}, {15'h0000, adc_start});
		if (t != 2'h3) begin
			chk("channel", {14'h0000, t}, {14'h0000, adc_channel});
			chk("setup a", su[t][0], adc_setup_a);
			chk("setup b", su[t][1], adc_setup_b);
			chk("source", {12'h000, s}, {12'h000, adc_source_sel});
			chk("pins", {14'h0000, s == 4'h8, s == 4'h9}, {14'h0000, adc_pos, adc_neg});
			res[t] = su[t][0] + su[t][1] + {s, 10'h000, t};
		end
		for (int i = 0; i < 40 && cpu_halt !== 1'h0; i++) begin
			@(posedge core_clk);
			#1;
		end
		if (cpu_halt !== 1'h0) begin
			n_mismatch++;
			stop_test();
		end
		reg_rd(`OFS_CONTROL, c & 16'h0F00, "control");
		for (int k = 0; k < 3; k++) reg_rd(raddr[k], res[k], "result");
	endtask : conv

	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end

	initial begin
		repeat (5) @(posedge core_clk);
		#1 resetn = 1'h1;
		for (int a = 0; a < 10; a++) reg_rd(a[7:0], rstv[a], "reset value");
		reg_rd(8'h0A, 16'h0000, "unmapped");
		for (int t = 0; t < 3; t++) begin
			for (int j = 0; j < 2; j++) begin
				su[t][j] = rnd();
				reg_wr(saddr[t][j], su[t][j]);
				reg_rd(saddr[t][j], su[t][j], "setup");
			end
		end
		reg_wr(`OFS_CHAN1_RESULT, 16'hBEEF);
		reg_rd(`OFS_CHAN1_RESULT, 16'h0000, "read-only result");
		foreach (clist[i]) conv(clist[i]);
		repeat (10) conv(rnd());
		stop_test();
	end
endmodule : adc_conversion_control_tb
